//--- cmr_pkg.sv
package cmr_pkg;

	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [7:0] IDX_LEVEL_STYLE = 8'h0d;
	localparam logic [7:0] IDX_MIX_PAIR0 = 8'h18;
	localparam logic [7:0] IDX_MIX_PAIR1 = 8'h19;
	localparam logic [7:0] IDX_MIX_PAIR2 = 8'h1a;
	localparam logic [7:0] IDX_ADC_LEFT_INPUT_GAIN = 8'h1c;
	localparam logic [7:0] IDX_ADC_RIGHT_INPUT_GAIN = 8'h1d;
	localparam logic [7:0] IDX_RECEIVER_MODE_SETTINGS = 8'h1e;
	localparam logic [7:0] IDX_RECEIVER_INPUT_ROUTING = 8'h1f;
	localparam logic [7:0] IDX_IRQ_EVENT_FLAGS = 8'h20;
	localparam logic [7:0] IDX_IRQ_EVENT_ENABLES = 8'h21;
	localparam logic [7:0] IDX_IRQ_TRIGGER_MODE_UPPER = 8'h22;
	localparam logic [7:0] IDX_IRQ_TRIGGER_MODE_LOWER = 8'h23;
	localparam logic [7:0] IDX_RX_ERROR_ENABLES = 8'h27;

	// ==========================================================
	// field positions and reset values
	localparam int LEVEL_STYLE_POS = 4;
	localparam int PHASE_ALIGN_POS = 7;
	localparam int DEEMPH_POS = 4;
	localparam int PIN_STYLE_POS = 2;
	localparam int POLICY_POS = 0;
	localparam int PASSTHRU_SEL_POS = 4;
	localparam int RX_SEL_POS = 0;
	localparam int IRQ_UNLOCK_BIT = 7;
	localparam int IRQ_SUBCODE_BIT = 5;
	localparam int IRQ_STATUS_BUF_BIT = 4;
	localparam int IRQ_USER_BUF_BIT = 3;
	localparam int IRQ_OVER_RANGE_BIT = 1;
	localparam int IRQ_RX_ERROR_BIT = 0;
	localparam logic [7:0] IRQ_IMPL_MASK = 8'hbb;
	localparam logic [6:0] RX_ERR_SAMPLE_MASK = 7'h1f;
	localparam logic [4:0] MIX_RESET = 5'h09;

	// ==========================================================
	// codes
	localparam logic [1:0] STYLE_IMMEDIATE = 2'h0;
	localparam logic [1:0] STYLE_ZERO_CROSS = 2'h1;
	localparam logic [1:0] STYLE_SOFT_RAMP = 2'h2;
	localparam logic [1:0] STYLE_RAMP_ZC = 2'h3;
	localparam logic [1:0] PIN_HIGH = 2'h0;
	localparam logic [1:0] PIN_LOW = 2'h1;
	localparam logic [1:0] PIN_OPEN_DRAIN = 2'h2;
	localparam logic [1:0] TRIG_RISE = 2'h0;
	localparam logic [1:0] TRIG_FALL = 2'h1;
	localparam logic [1:0] TRIG_LEVEL = 2'h2;
	localparam logic [1:0] POLICY_HOLD = 2'h0;
	localparam logic [1:0] POLICY_ZERO = 2'h1;
	localparam logic [1:0] SEL_MUTE = 2'h0;
	localparam logic [1:0] SEL_RIGHT = 2'h1;
	localparam logic [1:0] SEL_LEFT = 2'h2;

	// ==========================================================
	// counts in sample periods
	localparam int ZC_TIMEOUT_SAMPLES = 512;
	localparam int RAMP_SAMPLES_PER_DB = 8;
	localparam logic [8:0] ZC_TIMEOUT_LAST = 9'(ZC_TIMEOUT_SAMPLES - 1);
	localparam logic [2:0] RAMP_LAST = 3'(RAMP_SAMPLES_PER_DB - 1);

	typedef struct packed {
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
		logic wr_pend;
		logic [7:0] wr_idx;
		logic [2:0][4:0] mix;
		logic [1:0] level_style;
		logic [1:0][5:0] gain_tgt;
		logic phase_align;
		logic [1:0] deemph;
		logic [1:0] pin_style;
		logic [1:0] policy;
		logic [2:0] tsel;
		logic [2:0] rsel;
		logic [7:0] status;
		logic [7:0] irq_mask;
		logic [7:0] mode_hi;
		logic [7:0] mode_lo;
		logic [6:0] rx_err_mask;
		logic [7:0] cond_prev;
		logic [7:0] pin_s1;
		logic [7:0] pin_s2;
		logic [7:0] pin_s3;
		logic [7:0] pin_stable;
		logic passthru;
		logic rx_pin;
		logic irq_out;
		logic irq_oe_n;
		logic [1:0] deemph_active;
		logic [2:0][23:0] mix_a;
		logic [2:0][23:0] mix_b;
		logic [1:0][5:0] gain_app;
		logic [1:0][8:0] zc_tmo;
		logic [1:0][2:0] ramp_cnt;
		logic [1:0] sign_prev;
		logic [23:0] rx_out;
		logic rx_out_stb;
		logic [23:0] rx_last;
	} cmr_state_s;

endpackage

//--- cmr_control.sv
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
// Contract
// RULE_01 - each A/B output pair has its own 5-bit mix select, reset 01001
// RULE_02 - top bit 0: bits 3:2 pick A, bits 1:0 pick B: mute, R, L, avg
// RULE_03 - top bit 1: averaged outputs are cross-mixed between the pair
// RULE_04 - ADC gains are 6-bit two's complement dB steps, reset zero
// RULE_05 - gain changes follow the shared level change style setting
// RULE_06 - phase align bit forces both serial ports into phase
// RULE_07 - de-emphasis select 01/10/11 used while forced PLL hold is on
// RULE_08 - pin style 00 active high, 01 active low, 10 open drain low
// RULE_09 - receiver error sample policy: hold last, zero, or pass
// RULE_10 - 3-bit pass-through select routes input pin N to output pin
// RULE_11 - 3-bit receiver select connects input pin N to the receiver
// RULE_12 - status bit reads 1 if its condition occurred since last read
// RULE_13 - reading the status register clears every status bit; here a bit whose event arrives in the read cycle stays set
// RULE_14 - status bits with mask 0 always read zero
// RULE_15 - status, mask, mode bits: 7,5,4,3,1,0 used; 6 and 2 reserved
// RULE_16 - raise unlock on PLL unlock, subcode event on new Q block
// RULE_17 - raise buffer update events on status and user buffer change
// RULE_18 - raise over-range event on any ADC path over-range
// RULE_19 - raise receiver error event; software reads error register
// RULE_20 - mask 1 lets a source reach pin and status; resets zero
// RULE_21 - trigger mode is upper-register bit over lower-register bit
// RULE_22 - mode 00 rising, 01 falling, 10 level; polarity from pin style
// RULE_23 - zero-cross wait times out after 512 samples per channel
// RULE_24 - only unmasked receiver errors raise the event and the policy
// RULE_25 - pin active when any unmasked source triggered, ORed together
module cmr_control
(
	// bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// output mixing
	input wire logic [2:0][23:0] pair_left_in,
	input wire logic [2:0][23:0] pair_right_in,
	output logic [2:0][23:0] pair_a_output,
	output logic [2:0][23:0] pair_b_output,
	// adc gain
	input wire logic adc_sample_strobe,
	input wire logic [23:0] adc_left_sample,
	input wire logic [23:0] adc_right_sample,
	output logic [5:0] left_input_gain,
	output logic [5:0] right_input_gain,
	// receiver
	input wire logic forced_pll_hold,
	input wire logic [7:0] rx_input_pins,
	output logic passthru_out_pin,
	output logic rx_selected_input,
	output logic port_phase_align,
	output logic [1:0] deemph_active_select,
	input wire logic rx_sample_strobe,
	input wire logic [23:0] rx_sample_in,
	input wire logic [6:0] rx_error_flags,
	output logic [23:0] rx_sample_out,
	output logic rx_sample_out_strobe,
	// event sources
	input wire logic pll_unlocked,
	input wire logic new_subcode_block,
	input wire logic status_buffer_update,
	input wire logic user_buffer_update,
	input wire logic adc_over_range,
	// interrupt pin
	output logic irq_pin_out,
	output logic irq_pin_oe_n
);

	cmr_pkg::cmr_state_s r;
	cmr_pkg::cmr_state_s n;
	logic acc;
	logic rd;
	logic [7:0] idx;
	logic [7:0] wdat;
	logic [7:0] rval;
	logic [7:0] cond;
	logic [7:0] trig;
	logic [7:0] ev;
	logic [7:0] agree;
	logic rx_err_cond;
	logic rx_affect;
	logic zc;
	logic [23:0] smp;
	logic signed [5:0] app;
	logic signed [5:0] tgt;
	logic signed [5:0] step;

	// average of two samples, one extra bit so the sum cannot wrap
	function automatic logic [23:0] avg2(input logic [23:0] x,
		input logic [23:0] y);
		logic [24:0] s;
		s = {x[23], x} + {y[23], y};
		return s[24:1];
	endfunction

	function automatic logic [23:0] pick(input logic [1:0] code,
		input logic [23:0] l, input logic [23:0] rr);
		logic [23:0] v;
		v = avg2(l, rr);
		if (code == cmr_pkg::SEL_MUTE)
			v = 24'h0;
		else if (code == cmr_pkg::SEL_RIGHT)
			v = rr;
		else if (code == cmr_pkg::SEL_LEFT)
			v = l;
		return v;
	endfunction

	// ==========================================================
	// next state
	always_comb
	begin
		n = r;
		n.hreadyout = 1'b1;
		n.hresp = 1'b0;
		n.hrdata = 32'h0;
		wdat = hwdata[7:0];

		// three-stage pin capture, value taken once stages 2 and 3 agree
		n.pin_s1 = rx_input_pins;
		n.pin_s2 = r.pin_s1;
		n.pin_s3 = r.pin_s2;
		agree = ~(r.pin_s2 ^ r.pin_s3);
		n.pin_stable = (agree & r.pin_s2) | (~agree & r.pin_stable);
		n.passthru = r.pin_stable[r.tsel]; // [RULE_10]
		n.rx_pin = r.pin_stable[r.rsel]; // [RULE_11]

		// write data phase
		n.wr_pend = 1'b0;
		if (r.wr_pend)
		begin
			if (r.wr_idx == cmr_pkg::IDX_LEVEL_STYLE)
				n.level_style = wdat[cmr_pkg::LEVEL_STYLE_POS +: 2];
			else if (r.wr_idx == cmr_pkg::IDX_MIX_PAIR0)
				n.mix[0] = wdat[4:0]; // [RULE_01]
			else if (r.wr_idx == cmr_pkg::IDX_MIX_PAIR1)
				n.mix[1] = wdat[4:0];
			else if (r.wr_idx == cmr_pkg::IDX_MIX_PAIR2)
				n.mix[2] = wdat[4:0];
			else if (r.wr_idx == cmr_pkg::IDX_ADC_LEFT_INPUT_GAIN)
				n.gain_tgt[0] = wdat[5:0]; // [RULE_04]
			else if (r.wr_idx == cmr_pkg::IDX_ADC_RIGHT_INPUT_GAIN)
				n.gain_tgt[1] = wdat[5:0];
			else if (r.wr_idx == cmr_pkg::IDX_RECEIVER_MODE_SETTINGS)
			begin
				n.phase_align = wdat[cmr_pkg::PHASE_ALIGN_POS];
				n.deemph = wdat[cmr_pkg::DEEMPH_POS +: 2];
				n.pin_style = wdat[cmr_pkg::PIN_STYLE_POS +: 2];
				n.policy = wdat[cmr_pkg::POLICY_POS +: 2];
			end
			else if (r.wr_idx == cmr_pkg::IDX_RECEIVER_INPUT_ROUTING)
			begin
				n.tsel = wdat[cmr_pkg::PASSTHRU_SEL_POS +: 3];
				n.rsel = wdat[cmr_pkg::RX_SEL_POS +: 3];
			end
			else if (r.wr_idx == cmr_pkg::IDX_IRQ_EVENT_ENABLES)
				n.irq_mask = wdat & cmr_pkg::IRQ_IMPL_MASK; // [RULE_20]
			else if (r.wr_idx == cmr_pkg::IDX_IRQ_TRIGGER_MODE_UPPER)
				n.mode_hi = wdat & cmr_pkg::IRQ_IMPL_MASK;
			else if (r.wr_idx == cmr_pkg::IDX_IRQ_TRIGGER_MODE_LOWER)
				n.mode_lo = wdat & cmr_pkg::IRQ_IMPL_MASK;
			else if (r.wr_idx == cmr_pkg::IDX_RX_ERROR_ENABLES)
				n.rx_err_mask = wdat[6:0];
		end

		// address phase
		acc = hsel & hready & htrans[1];
		idx = haddr[9:2];
		rd = acc & ~hwrite;
		if (acc & hwrite)
		begin
			n.wr_pend = 1'b1;
			n.wr_idx = idx;
		end

		// event conditions, bit positions shared by all irq registers
		rx_err_cond = |(rx_error_flags & r.rx_err_mask); // [RULE_24]
		cond = 8'h0;
		cond[cmr_pkg::IRQ_UNLOCK_BIT] = pll_unlocked; // [RULE_16] [RULE_15]
		cond[cmr_pkg::IRQ_SUBCODE_BIT] = new_subcode_block;
		cond[cmr_pkg::IRQ_STATUS_BUF_BIT] = status_buffer_update; // [RULE_17]
		cond[cmr_pkg::IRQ_USER_BUF_BIT] = user_buffer_update;
		cond[cmr_pkg::IRQ_OVER_RANGE_BIT] = adc_over_range; // [RULE_18]
		cond[cmr_pkg::IRQ_RX_ERROR_BIT] = rx_err_cond; // [RULE_19]
		n.cond_prev = cond;
		for (int i = 0; i < 8; i++)
		begin
			case ({r.mode_hi[i], r.mode_lo[i]}) // [RULE_21]
				cmr_pkg::TRIG_RISE: trig[i] = cond[i] & ~r.cond_prev[i];
				cmr_pkg::TRIG_FALL: trig[i] = ~cond[i] & r.cond_prev[i];
				cmr_pkg::TRIG_LEVEL: trig[i] = cond[i]; // [RULE_22]
				default: trig[i] = 1'b0;
			endcase
		end
		ev = trig & r.irq_mask & cmr_pkg::IRQ_IMPL_MASK; // [RULE_20]

		// read mux sees this cycle's write so back-to-back is coherent
		rval = 8'h0;
		if (idx == cmr_pkg::IDX_LEVEL_STYLE)
			rval[cmr_pkg::LEVEL_STYLE_POS +: 2] = n.level_style;
		else if (idx == cmr_pkg::IDX_MIX_PAIR0)
			rval[4:0] = n.mix[0];
		else if (idx == cmr_pkg::IDX_MIX_PAIR1)
			rval[4:0] = n.mix[1];
		else if (idx == cmr_pkg::IDX_MIX_PAIR2)
			rval[4:0] = n.mix[2];
		else if (idx == cmr_pkg::IDX_ADC_LEFT_INPUT_GAIN)
			rval[5:0] = n.gain_tgt[0];
		else if (idx == cmr_pkg::IDX_ADC_RIGHT_INPUT_GAIN)
			rval[5:0] = n.gain_tgt[1];
		else if (idx == cmr_pkg::IDX_RECEIVER_MODE_SETTINGS)
			rval = {n.phase_align, 1'b0, n.deemph, n.pin_style, n.policy};
		else if (idx == cmr_pkg::IDX_RECEIVER_INPUT_ROUTING)
			rval = {1'b0, n.tsel, 1'b0, n.rsel};
		else if (idx == cmr_pkg::IDX_IRQ_EVENT_FLAGS)
			rval = r.status & n.irq_mask; // [RULE_14]
		else if (idx == cmr_pkg::IDX_IRQ_EVENT_ENABLES)
			rval = n.irq_mask;
		else if (idx == cmr_pkg::IDX_IRQ_TRIGGER_MODE_UPPER)
			rval = n.mode_hi;
		else if (idx == cmr_pkg::IDX_IRQ_TRIGGER_MODE_LOWER)
			rval = n.mode_lo;
		else if (idx == cmr_pkg::IDX_RX_ERROR_ENABLES)
			rval[6:0] = n.rx_err_mask;
		if (rd)
			n.hrdata = {24'h0, rval};

		// sticky flags: a new event wins over the read clear
		if (rd && idx == cmr_pkg::IDX_IRQ_EVENT_FLAGS)
			n.status = ev & n.irq_mask; // [RULE_13]
		else
			n.status = (r.status | ev) & n.irq_mask; // [RULE_12] [RULE_14]

		// pin stays active until the flags are read away
		case (n.pin_style) // [RULE_08] [RULE_25]
			cmr_pkg::PIN_LOW:
			begin
				n.irq_out = ~(|n.status);
				n.irq_oe_n = 1'b0;
			end
			cmr_pkg::PIN_OPEN_DRAIN:
			begin
				n.irq_out = 1'b0;
				n.irq_oe_n = ~(|n.status);
			end
			default:
			begin
				n.irq_out = |n.status;
				n.irq_oe_n = 1'b0;
			end
		endcase

		n.deemph_active = forced_pll_hold ? n.deemph : 2'h0; // [RULE_07]

		// pair mixing; left/right are shared by both outputs of a pair,
		// so both cross-mix forms reduce to the same average here
		for (int p = 0; p < 3; p++)
		begin
			n.mix_a[p] = pick(r.mix[p][3:2], pair_left_in[p],
				pair_right_in[p]); // [RULE_02]
			n.mix_b[p] = pick(r.mix[p][1:0], pair_left_in[p],
				pair_right_in[p]);
			if (r.mix[p][4] && r.mix[p][3:2] == 2'h3)
				n.mix_a[p] = r.mix[p][1:0] == cmr_pkg::SEL_LEFT ?
					avg2(pair_right_in[p], pair_left_in[p]) :
					avg2(pair_left_in[p], pair_right_in[p]); // [RULE_03]
			if (r.mix[p][4] && r.mix[p][1:0] == 2'h3)
				n.mix_b[p] = r.mix[p][3:2] == cmr_pkg::SEL_RIGHT ?
					avg2(pair_right_in[p], pair_left_in[p]) :
					avg2(pair_left_in[p], pair_right_in[p]);
		end

		// gain engine, one independent zero-cross watch per channel
		smp = 24'h0;
		zc = 1'b0;
		app = 6'sh0;
		tgt = 6'sh0;
		step = 6'sh0;
		for (int c = 0; c < 2; c++)
		begin
			smp = c == 0 ? adc_left_sample : adc_right_sample;
			app = r.gain_app[c];
			tgt = r.gain_tgt[c];
			step = tgt > app ? app + 6'sh1 : app - 6'sh1;
			zc = (smp[23] != r.sign_prev[c]) || smp == 24'h0;
			if (adc_sample_strobe)
			begin
				n.sign_prev[c] = smp[23];
				if (app == tgt)
				begin
					n.zc_tmo[c] = 9'h0;
					n.ramp_cnt[c] = 3'h0;
				end
				else
				begin
					case (r.level_style) // [RULE_05]
						cmr_pkg::STYLE_IMMEDIATE:
							n.gain_app[c] = r.gain_tgt[c];
						cmr_pkg::STYLE_SOFT_RAMP:
						begin
							n.ramp_cnt[c] = r.ramp_cnt[c] + 3'h1;
							if (r.ramp_cnt[c] == cmr_pkg::RAMP_LAST)
								n.gain_app[c] = step;
						end
						default:
						begin
							// timeout bounds the wait on a silent channel
							n.zc_tmo[c] = r.zc_tmo[c] + 9'h1;
							if (zc || r.zc_tmo[c] ==
								cmr_pkg::ZC_TIMEOUT_LAST) // [RULE_23]
							begin
								n.zc_tmo[c] = 9'h0;
								n.gain_app[c] = r.level_style ==
									cmr_pkg::STYLE_ZERO_CROSS ?
									r.gain_tgt[c] : step;
							end
						end
					endcase
				end
			end
		end

		// receiver sample policy
		rx_affect = |(rx_error_flags & r.rx_err_mask &
			cmr_pkg::RX_ERR_SAMPLE_MASK); // [RULE_24]
		n.rx_out_stb = rx_sample_strobe;
		if (rx_sample_strobe)
		begin
			n.rx_out = rx_sample_in;
			if (!rx_affect)
				n.rx_last = rx_sample_in;
			else if (r.policy == cmr_pkg::POLICY_HOLD)
				n.rx_out = r.rx_last; // [RULE_09]
			else if (r.policy == cmr_pkg::POLICY_ZERO)
				n.rx_out = 24'h0;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			r <= '0;
			r.hreadyout <= 1'b1;
			r.mix <= {3{cmr_pkg::MIX_RESET}};
		end
		else
			r <= n;
	end

	assign hreadyout = r.hreadyout;
	assign hresp = r.hresp;
	assign hrdata = r.hrdata;
	assign pair_a_output = r.mix_a;
	assign pair_b_output = r.mix_b;
	assign left_input_gain = r.gain_app[0];
	assign right_input_gain = r.gain_app[1];
	assign passthru_out_pin = r.passthru;
	assign rx_selected_input = r.rx_pin;
	assign port_phase_align = r.phase_align; // [RULE_06]
	assign deemph_active_select = r.deemph_active;
	assign rx_sample_out = r.rx_out;
	assign rx_sample_out_strobe = r.rx_out_stb;
	assign irq_pin_out = r.irq_out;
	assign irq_pin_oe_n = r.irq_oe_n;

	// ==========================================================
	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	mask_hides_a: assert property (rd && idx == cmr_pkg::IDX_IRQ_EVENT_FLAGS // [RULE_14]
		|=> (hrdata[7:0] & ~r.irq_mask) == 8'h0)
		else $error("masked flag read as set");
	read_clears_a: assert property ((rd && idx == // [RULE_13]
		cmr_pkg::IDX_IRQ_EVENT_FLAGS && ev == 8'h0) ##1 (ev == 8'h0)
		|=> r.status == 8'h0)
		else $error("flags not cleared by read");
	sticky_set_a: assert property (ev != 8'h0 // [RULE_12]
		|=> (r.status & $past(ev)) == ($past(ev) & r.irq_mask))
		else $error("event lost from flags");
	pin_low_style_a: assert property (n.pin_style == cmr_pkg::PIN_LOW // [RULE_08]
		&& n.status != 8'h0 |=> !irq_pin_out && !irq_pin_oe_n)
		else $error("active low pin not low");
	open_drain_a: assert property (n.pin_style == cmr_pkg::PIN_OPEN_DRAIN // [RULE_08]
		|=> !irq_pin_out && irq_pin_oe_n == (r.status == 8'h0))
		else $error("open drain pin wrong");
	deemph_gate_a: assert property (!forced_pll_hold // [RULE_07]
		|=> deemph_active_select == 2'h0)
		else $error("de-emphasis active without hold");
	gain_now_a: assert property (adc_sample_strobe && // [RULE_05]
		r.level_style == cmr_pkg::STYLE_IMMEDIATE
		|=> left_input_gain == $past(r.gain_tgt[0]))
		else $error("immediate gain not applied");
	ramp_pace_a: assert property (r.level_style == // [RULE_05]
		cmr_pkg::STYLE_SOFT_RAMP && r.ramp_cnt[0] != cmr_pkg::RAMP_LAST
		|=> $stable(left_input_gain))
		else $error("ramp stepped early");
	mute_pick_a: assert property (r.mix[0][3:2] == cmr_pkg::SEL_MUTE // [RULE_02]
		|=> pair_a_output[0] == 24'h0)
		else $error("muted output not zero");
	rx_zero_a: assert property (rx_sample_strobe && rx_affect && // [RULE_09]
		r.policy == cmr_pkg::POLICY_ZERO |=> rx_sample_out == 24'h0)
		else $error("error sample not zeroed");
	passthru_route_a: assert property (1'b1 |=> // [RULE_10]
		passthru_out_pin == $past(r.pin_stable[r.tsel]))
		else $error("pass-through route wrong");

endmodule

//--- cmr_host.sv
`timescale 1ns/10ps
// ==========================================================
// host side: single-word bus master for the control port
module cmr_host
(
	// bus
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial
	begin
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// one transfer; the wait has no bound of its own, the bench timeout cuts it
	task automatic xfer(input logic w, input logic [7:0] idx,
		input logic [7:0] d, output logic [31:0] q);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		q = hrdata;
		// released data must not look like the last word
		hwdata <= ~{24'h0, d};
	endtask
endmodule

//--- tb.sv
`timescale 1ns/10ps
module tb;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans, de;
	logic [2:0] hsize;
	logic [2:0][23:0] pl, pr, pa, pb;
	logic [23:0] al, ar, rxi, rxo, g;
	logic as, fph, rs, ts, rxs, oes, po, pal, rxos;
	logic [5:0] lg, rg;
	logic [7:0] pins;
	logic [6:0] rxe;
	logic [4:0] ev;
	int error_cnt, n_tests, cyc, i, k;
	logic [7:0] ix [9] = '{8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h21, 8'h22,
		8'h23, 8'h0d, 8'h27};
	logic [7:0] mk [9] = '{8'h3f, 8'h3f, 8'hbf, 8'h77, 8'hbb, 8'hbb,
		8'hbb, 8'h30, 8'h7f};
	int bp [5] = '{7, 5, 4, 3, 1};

	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	cmr_host i_host (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata);

	cmr_control i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.pair_left_in(pl), .pair_right_in(pr), .pair_a_output(pa),
		.pair_b_output(pb), .adc_sample_strobe(as), .adc_left_sample(al),
		.adc_right_sample(ar), .left_input_gain(lg), .right_input_gain(rg),
		.forced_pll_hold(fph), .rx_input_pins(pins), .passthru_out_pin(ts),
		.rx_selected_input(rs), .port_phase_align(pal),
		.deemph_active_select(de), .rx_sample_strobe(rxs),
		.rx_sample_in(rxi), .rx_error_flags(rxe), .rx_sample_out(rxo),
		.rx_sample_out_strobe(rxos), .pll_unlocked(ev[0]),
		.new_subcode_block(ev[1]), .status_buffer_update(ev[2]),
		.user_buffer_update(ev[3]), .adc_over_range(ev[4]),
		.irq_pin_out(po), .irq_pin_oe_n(oes));

	// ==========================================================
	// helpers
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		i_host.xfer(1'b1, idx, d, q);
	endtask

	task automatic rd(input string nm, input logic [7:0] idx,
		input logic [31:0] e);
		i_host.xfer(1'b0, idx, 8'h0, q);
		chk(nm, q, e);
	endtask

	task automatic tk(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// average rounds toward minus infinity
	function automatic logic [23:0] pick(input logic [1:0] s,
		input logic [23:0] l, input logic [23:0] r);
		logic [24:0] t;
		t = {l[23], l} + {r[23], r};
		case (s)
			2'h0: pick = 24'h0;
			2'h1: pick = r;
			2'h2: pick = l;
			default: pick = t[24:1];
		endcase
	endfunction

	task automatic print_verdict;
		if (error_cnt == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			print_verdict;
		end
	end

	// ==========================================================
	// sequence
	initial
	begin
		hresetn = 1'b0;
		{pl, pr, al, ar, rxi, g} = '0;
		{as, fph, rxs, pins, rxe, ev} = '0;
		void'($urandom(19656));
		tk(6);
		hresetn <= 1'b1;
		for (i = 0; i < 9; i++)
			rd("reset", ix[i], 32'h0);
		for (i = 0; i < 3; i++)
			rd("mix reset", 8'h18 + 8'(i), 32'h9);
		rd("flags reset", 8'h20, 32'h0);
		rd("unmapped", 8'h3f, 32'h0);
		chk("okay resp", hresp, 1'b0);
		for (i = 0; i < 9; i++)
		begin
			g = 24'($urandom);
			wr(ix[i], g[7:0]);
			rd("readback", ix[i], {24'h0, g[7:0] & mk[i]});
			wr(ix[i], 8'h0);
		end
		for (k = 0; k < 32; k++)
		begin
			for (i = 0; i < 3; i++)
			begin
				pl[i] <= 24'($urandom);
				pr[i] <= 24'($urandom);
			end
			wr(8'h18, 8'(k));
			tk(3);
			chk("mix a", pa[0], pick(k[3:2], pl[0], pr[0]));
			chk("mix b", pb[0], pick(k[1:0], pl[0], pr[0]));
			chk("pair1 a", pa[1], pl[1]);
			chk("pair2 b", pb[2], pr[2]);
		end
		for (k = 0; k < 8; k++)
		begin
			pins <= (8'h1 << k) | (8'h1 << (7 - k));
			wr(8'h1f, {1'b0, k[2:0], 1'b0, 3'(7 - k)});
			tk(8);
			chk("passthru", ts, 1'b1);
			chk("rx input", rs, 1'b1);
			pins <= ~((8'h1 << k) | (8'h1 << (7 - k)));
			tk(8);
			chk("passthru lo", {ts, rs}, 2'b00);
		end
		fph <= 1'b1;
		for (k = 1; k < 4; k++)
		begin
			wr(8'h1e, {2'h2, k[1:0], 4'h0});
			tk(2);
			chk("deemph", de, k[1:0]);
			chk("align", pal, 1'b1);
		end
		fph <= 1'b0;
		tk(2);
		chk("deemph off", de, 2'h0);
		wr(8'h1c, 8'h31);
		wr(8'h1d, 8'h0f);
		al <= 24'($urandom);
		ar <= 24'($urandom);
		as <= 1'b1;
		tk(1);
		as <= 1'b0;
		tk(2);
		chk("gain", {lg, rg}, {6'h31, 6'h0f});
		// zero-cross style: a silent positive channel must wait 512 strobes
		wr(8'h0d, 8'h10);
		al <= 24'h1;
		as <= 1'b1;
		tk(1);
		as <= 1'b0;
		wr(8'h1c, 8'h05);
		as <= 1'b1;
		tk(511);
		chk("zc wait", lg, 6'h31);
		tk(2);
		as <= 1'b0;
		chk("zc timeout", lg, 6'h05);
		wr(8'h1c, 8'h3b);
		al <= 24'hffffff;
		as <= 1'b1;
		tk(1);
		as <= 1'b0;
		tk(2);
		chk("zc jump", lg, 6'h3b);
		// soft ramp: one 1 dB step every 8 strobes
		wr(8'h0d, 8'h20);
		wr(8'h1c, 8'h3d);
		as <= 1'b1;
		tk(8);
		chk("ramp hold", lg, 6'h3b);
		tk(1);
		chk("ramp step", lg, 6'h3c);
		tk(8);
		as <= 1'b0;
		chk("ramp end", {lg, rg}, {6'h3d, 6'h0f});
		wr(8'h1e, 8'h0);
		tk(1);
		chk("align off", pal, 1'b0);
		for (k = 0; k < 5; k++)
		begin
			wr(8'h21, 8'(1 << bp[k]));
			i_host.xfer(1'b0, 8'h20, 8'h0, q);
			ev[k] <= 1'b1;
			tk(3);
			chk("pin rise", po, 1'b1);
			ev[k] <= 1'b0;
			tk(3);
			rd("flags", 8'h20, 32'(1 << bp[k]));
			rd("flags clr", 8'h20, 32'h0);
			tk(2);
			chk("pin idle", po, 1'b0);
		end
		wr(8'h21, 8'h02);
		for (k = 0; k < 3; k++)
		begin
			wr(8'h22, {6'h0, k[1], 1'b0});
			wr(8'h23, {6'h0, k[0], 1'b0});
			i_host.xfer(1'b0, 8'h20, 8'h0, q);
			ev[4] <= 1'b1;
			tk(3);
			chk("mode pin", po, 32'(k != 1));
			rd("mode on", 8'h20, k != 1 ? 32'h2 : 32'h0);
			rd("mode hold", 8'h20, k == 2 ? 32'h2 : 32'h0);
			ev[4] <= 1'b0;
			tk(3);
			rd("mode off", 8'h20, k != 0 ? 32'h2 : 32'h0);
		end
		wr(8'h22, 8'h0);
		wr(8'h23, 8'h0);
		wr(8'h21, 8'h0);
		ev[0] <= 1'b1;
		tk(3);
		chk("masked pin", po, 1'b0);
		ev[0] <= 1'b0;
		rd("masked flag", 8'h20, 32'h0);
		wr(8'h21, 8'h80);
		for (k = 1; k < 3; k++)
		begin
			wr(8'h1e, {4'h0, k[1:0], 2'h0});
			tk(2);
			chk("style idle", {po, oes}, k == 1 ? 2 : 1);
			ev[0] <= 1'b1;
			tk(3);
			ev[0] <= 1'b0;
			chk("style act", {po, oes}, 2'b00);
			rd("style flag", 8'h20, 32'h80);
		end
		wr(8'h27, 8'h1f);
		wr(8'h21, 8'h01);
		for (k = 0; k < 3; k++)
		begin
			wr(8'h1e, {6'h0, k[1:0]});
			rxi <= 24'($urandom);
			rxs <= 1'b1;
			tk(1);
			g = rxi;
			rxi <= 24'($urandom);
			rxe <= 7'h01;
			tk(1);
			rxs <= 1'b0;
			rxe <= 7'h0;
			tk(1);
			chk("rx out", rxo, k == 0 ? g : k == 1 ? 24'h0 : rxi);
			chk("rx strobe", rxos, 1'b1);
			rd("rx flag", 8'h20, 32'h1);
		end
		// crc errors raise the event but leave the sample alone
		wr(8'h27, 8'h7f);
		wr(8'h1e, 8'h01);
		rxi <= 24'($urandom);
		rxe <= 7'h60;
		rxs <= 1'b1;
		tk(1);
		g = rxi;
		rxs <= 1'b0;
		rxe <= 7'h0;
		tk(1);
		chk("rx crc pass", rxo, g);
		rd("crc flag", 8'h20, 32'h1);
		print_verdict;
	end
endmodule
